/* File: hw/pcg_pkg.sv */
// package: constants, register map and types of the clock generation control block
package pcg_pkg;

   // ----------------------------------------------------------------
   // register map (byte addresses on the apb bus)
   // ----------------------------------------------------------------
   localparam logic [7:0] PCG_OFS_CTRL = 8'h00;
   localparam logic [7:0] PCG_OFS_DIV = 8'h04;
   localparam logic [7:0] PCG_OFS_STAT = 8'h08;

   // control register bit positions
   localparam int PCG_CTRL_AUTO = 0;
   localparam int PCG_CTRL_ACQ = 1;
   localparam int PCG_CTRL_IRQEN = 2;
   localparam int PCG_CTRL_PON = 3;
   localparam int PCG_CTRL_BSEL = 4;
   localparam int PCG_CTRL_MSEL = 5;
   localparam int PCG_CTRL_MON = 6;
   localparam int PCG_CTRL_LIMP = 7;

   // divider register fields
   localparam int PCG_DIV_REF_LSB = 0;
   localparam int PCG_DIV_MUL_LSB = 8;
   localparam int PCG_DIV_SLW_LSB = 16;

   // status register bit positions
   localparam int PCG_STAT_SETTLE = 0;
   localparam int PCG_STAT_TRACK = 1;
   localparam int PCG_STAT_PEND = 2;
   localparam int PCG_STAT_RUN = 3;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] PCG_CTRL_RST = 8'h48;
   localparam logic [2:0] PCG_REF_RST = 3'h0;
   localparam logic [5:0] PCG_MUL_RST = 6'h00;
   localparam logic [5:0] PCG_SLW_RST = 6'h00;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int PCG_CLK_PERIOD_NS = 20;
   localparam int PCG_STAB_TIME_US = 500;
   localparam int PCG_STAB_CYCLES = (PCG_STAB_TIME_US * 1000) / PCG_CLK_PERIOD_NS;

   // lock detector window in reference ticks, tolerance thresholds in feedback ticks
   localparam int PCG_WINDOW = 32;
   localparam int PCG_LOCK_SET = 1;
   localparam int PCG_LOCK_CLR = 2;
   localparam int PCG_TRK_SET = 2;
   localparam int PCG_UNT_CLR = 4;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      PCG_LS_OFF = 4'b0001,
      PCG_LS_RUN = 4'b0010,
      PCG_LS_STOP = 4'b0100,
      PCG_LS_STAB = 4'b1000
   } pcg_loop_t;

   typedef struct packed {
      logic limp_disable_bit;
      logic monitor_enable_bit;
      logic module_sel_slow;
      logic base_sel_loop;
      logic loop_power_on;
      logic settle_irq_enable;
      logic acquire_mode_bit;
      logic auto_bw;
   } pcg_ctrl_t;

   // generated clock levels, carried together
   typedef struct packed {
      logic system_base_clock;
      logic module_clock;
      logic slow_module_clock;
      logic can_clock;
      logic debug_module_clock;
      logic monitor_clock;
   } pcg_clocks_t;

endpackage

/* File: hw/pcg_clock_ctrl.sv */
// clock generation control: dividers, loop lock detector, clock selection, apb slave
//
// How it works
// - slow clock divides crystal by 4 to 252 in steps of 4; a zero divider passes the crystal through
// - module clock selects system base clock or slow module clock
// - slow module clock feeds periodic timer and watchdog; stop-restart delay counts system clock cycles
// - can clock picks external clock or system base clock by its select
// - debug clock picks debug clock or bus strobe clock by its select
// - monitor clock comes straight from external clock, not the loop
// - reference clock is crystal divided by 1 to 8
// - loop output is reference multiplied by 1 to 64
// - loop keeps running in wait mode while selected
// - stop suspends loop; resumes after stabilization at same frequency when automatic
// - lock detector compares feedback clock frequency with reference frequency
// - acquire bit reads zero in acquisition; one means tracking
// - automatic bandwidth lets the detector switch acquisition and tracking
// - automatic mode: acquire bit read-only, set inside track, cleared outside untrack
// - settled flag read-only, set inside lock tolerance, cleared outside the wider unlock tolerance
// - each settled flag toggle raises interrupt when enabled
// - manual mode keeps lock detection and interrupt; only switching disabled
// - manual mode: software writes acquire bit to choose filter mode
// - reset sets monitor enable and power-on, clears limp disable
`timescale 1ns/1ps
`default_nettype none

module pcg_clock_ctrl
   import pcg_pkg::*;
#(
   parameter int STAB_CYCLES = PCG_STAB_CYCLES,
   parameter int WINDOW = PCG_WINDOW,
   parameter int LOCK_SET = PCG_LOCK_SET,
   parameter int LOCK_CLR = PCG_LOCK_CLR,
   parameter int TRK_SET = PCG_TRK_SET,
   parameter int UNT_CLR = PCG_UNT_CLR
)
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clk_en,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // sampled clock levels and mode inputs
   input wire logic external_clock_in,
   input wire logic vco_output_clock,
   input wire logic debug_clock_in,
   input wire logic can_sel_system,
   input wire logic debug_sel_strobe,
   input wire logic stop_mode,
   input wire logic wait_mode,
   // generated clocks and loop controls
   output pcg_clocks_t clocks,
   output logic bus_strobe_clock,
   output logic calibration_out_clock,
   output logic final_reference_clock,
   output logic vco_feedback_clock,
   output logic loop_run,
   output logic filter_track,
   output logic monitor_enable,
   output logic limp_disable,
   output logic settle_irq
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      pcg_loop_t lstate;
      pcg_ctrl_t ctrl;
      logic [2:0] refdv;
      logic [5:0] mult;
      logic [5:0] slwdv;
      logic settle;
      logic trk;
      logic pend;
      logic xin_q;
      logic vco_q;
      logic [2:0] ref_cnt;
      logic [5:0] fb_cnt;
      logic [6:0] slw_cnt;
      logic slw_lvl;
      logic ref_tick;
      logic fb_tick;
      logic [7:0] win_cnt;
      logic [7:0] fbw_cnt;
      logic [19:0] stab_cnt;
      logic [31:0] rdata;
      logic ready;
      pcg_clocks_t clk;
      logic irq;
   } pcg_state_t;

   pcg_state_t s;
   pcg_state_t next_s;

   localparam logic [7:0] WIN_LAST = 8'(WINDOW - 1);
   localparam logic [7:0] WIN_VAL = 8'(WINDOW);
   localparam logic [19:0] STAB_LAST = 20'(STAB_CYCLES - 1);

   // frequency error of one window, as distance from the expected count
   function automatic logic [7:0] pcg_err(input logic [7:0] cnt);
      pcg_err = (cnt >= WIN_VAL) ? 8'(cnt - WIN_VAL) : 8'(WIN_VAL - cnt);
   endfunction

   // register address decode for the error answer; the read data path decodes on its own
   function automatic logic pcg_mapped(input logic [7:0] a);
      pcg_mapped = (a == PCG_OFS_CTRL) || (a == PCG_OFS_DIV) || (a == PCG_OFS_STAT);
   endfunction

   logic xin_rise;
   logic vco_rise;
   logic acq_eff;
   logic wr_fire;
   logic [7:0] err;
   logic win_end;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      next_s = s;
      xin_rise = external_clock_in & ~s.xin_q;
      vco_rise = vco_output_clock & ~s.vco_q;
      next_s.xin_q = external_clock_in;
      next_s.vco_q = vco_output_clock;
      wr_fire = psel & penable & pwrite & s.ready;
      err = pcg_err(s.fbw_cnt);
      win_end = s.ref_tick && (s.win_cnt == WIN_LAST);

      // reference divider: one tick per refdv+1 crystal edges
      next_s.ref_tick = 1'b0;
      if (xin_rise)
      begin
         if (s.ref_cnt >= s.refdv)
         begin
            next_s.ref_cnt = 3'h0;
            next_s.ref_tick = 1'b1;
         end
         else
            next_s.ref_cnt = 3'(s.ref_cnt + 3'h1);
      end

      // feedback divider: the loop settles when vco = reference * (mult+1)
      next_s.fb_tick = 1'b0;
      if (vco_rise && s.lstate == PCG_LS_RUN)
      begin
         if (s.fb_cnt >= s.mult)
         begin
            next_s.fb_cnt = 6'h00;
            next_s.fb_tick = 1'b1;
         end
         else
            next_s.fb_cnt = 6'(s.fb_cnt + 6'h01);
      end

      // slow divider: toggle every 2n crystal edges, so the period is 4n
      if (s.slwdv == 6'h00)
         next_s.slw_lvl = external_clock_in;
      else if (xin_rise)
      begin
         if (s.slw_cnt >= 7'({s.slwdv, 1'b0} - 7'h01))
         begin
            next_s.slw_cnt = 7'h00;
            next_s.slw_lvl = ~s.slw_lvl;
         end
         else
            next_s.slw_cnt = 7'(s.slw_cnt + 7'h01);
      end

      // lock detector: count feedback ticks across a window of reference ticks
      if (s.lstate == PCG_LS_RUN)
      begin
         if (s.fb_tick && s.fbw_cnt != 8'hFF)
            next_s.fbw_cnt = 8'(s.fbw_cnt + 8'h01);
         if (s.ref_tick)
            next_s.win_cnt = 8'(s.win_cnt + 8'h01);
         if (win_end)
         begin
            next_s.win_cnt = 8'h00;
            next_s.fbw_cnt = {7'h00, s.fb_tick};
            // hysteresis: entering needs a tighter error than leaving
            if (err <= 8'(LOCK_SET))
               next_s.settle = 1'b1;
            else if (err > 8'(LOCK_CLR))
               next_s.settle = 1'b0;
            if (s.ctrl.auto_bw && err <= 8'(TRK_SET))
               next_s.trk = 1'b1;
            else if (s.ctrl.auto_bw && err > 8'(UNT_CLR))
               next_s.trk = 1'b0;
         end
      end

      // loop power and low-power sequencing
      unique case (s.lstate)
         PCG_LS_OFF:
         begin
            next_s.settle = 1'b0;
            next_s.trk = 1'b0;
            if (s.ctrl.loop_power_on)
            begin
               next_s.lstate = PCG_LS_STAB;
               next_s.stab_cnt = 20'h00000;
            end
         end
         PCG_LS_RUN:
         begin
            // wait mode is not a reason to stop: only stop mode or power-off
            if (!s.ctrl.loop_power_on)
               next_s.lstate = PCG_LS_OFF;
            else if (stop_mode)
               next_s.lstate = PCG_LS_STOP;
         end
         PCG_LS_STOP:
         begin
            if (!s.ctrl.loop_power_on)
               next_s.lstate = PCG_LS_OFF;
            else if (!stop_mode)
            begin
               next_s.lstate = PCG_LS_STAB;
               next_s.stab_cnt = 20'h00000;
            end
         end
         PCG_LS_STAB:
         begin
            next_s.stab_cnt = 20'(s.stab_cnt + 20'h00001);
            if (!s.ctrl.loop_power_on)
               next_s.lstate = PCG_LS_OFF;
            else if (s.stab_cnt >= STAB_LAST)
            begin
               next_s.lstate = PCG_LS_RUN;
               next_s.win_cnt = 8'h00;
               next_s.fbw_cnt = 8'h00;
               // without automatic bandwidth the old frequency is not kept
               if (!s.ctrl.auto_bw)
               begin
                  next_s.trk = 1'b0;
                  next_s.ctrl.acquire_mode_bit = 1'b0;
               end
            end
         end
         default:
            next_s.lstate = PCG_LS_OFF;
      endcase

      // settle flag toggle interrupt, set wins over a write-one clear
      if (wr_fire && paddr == PCG_OFS_STAT && pwdata[PCG_STAT_PEND])
         next_s.pend = 1'b0;
      if (next_s.settle != s.settle && s.ctrl.settle_irq_enable)
         next_s.pend = 1'b1;

      // apb: the access phase takes one wait cycle so read data is registered
      next_s.ready = psel & penable & ~s.ready;
      if (psel && penable && !s.ready)
      begin
         next_s.rdata = 32'h00000000;
         if (paddr == PCG_OFS_CTRL)
         begin
            next_s.rdata[7:0] = s.ctrl;
            next_s.rdata[PCG_CTRL_ACQ] = acq_eff;
         end
         else if (paddr == PCG_OFS_DIV)
         begin
            next_s.rdata[PCG_DIV_REF_LSB +: 3] = s.refdv;
            next_s.rdata[PCG_DIV_MUL_LSB +: 6] = s.mult;
            next_s.rdata[PCG_DIV_SLW_LSB +: 6] = s.slwdv;
         end
         else if (paddr == PCG_OFS_STAT)
         begin
            next_s.rdata[PCG_STAT_SETTLE] = s.settle;
            next_s.rdata[PCG_STAT_TRACK] = acq_eff;
            next_s.rdata[PCG_STAT_PEND] = s.pend;
            next_s.rdata[PCG_STAT_RUN] = (s.lstate == PCG_LS_RUN);
         end
      end

      // register writes take effect on the completing edge
      if (wr_fire && paddr == PCG_OFS_CTRL)
      begin
         next_s.ctrl = pwdata[7:0];
         if (s.ctrl.auto_bw || pwdata[PCG_CTRL_AUTO])
            next_s.ctrl.acquire_mode_bit = s.ctrl.acquire_mode_bit;
         else
            next_s.ctrl.acquire_mode_bit = pwdata[PCG_CTRL_ACQ];
      end
      if (wr_fire && paddr == PCG_OFS_DIV)
      begin
         next_s.refdv = pwdata[PCG_DIV_REF_LSB +: 3];
         next_s.mult = pwdata[PCG_DIV_MUL_LSB +: 6];
         next_s.slwdv = pwdata[PCG_DIV_SLW_LSB +: 6];
      end

      // clock selection, all from sampled levels
      next_s.clk.system_base_clock = s.ctrl.base_sel_loop ? vco_output_clock
                                                          : external_clock_in;
      next_s.clk.slow_module_clock = s.slw_lvl;
      next_s.clk.module_clock = s.ctrl.module_sel_slow ? s.slw_lvl
                                                       : s.clk.system_base_clock;
      next_s.clk.can_clock = can_sel_system ? s.clk.system_base_clock
                                            : external_clock_in;
      next_s.clk.debug_module_clock = debug_sel_strobe ? s.clk.system_base_clock
                                                       : debug_clock_in;
      next_s.clk.monitor_clock = external_clock_in;
      // request follows the new enable, so clearing it silences a pending flag at once
      next_s.irq = next_s.pend & next_s.ctrl.settle_irq_enable;
   end

   // manual mode follows the software bit, automatic the detector
   assign acq_eff = s.ctrl.auto_bw ? s.trk : s.ctrl.acquire_mode_bit;

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s <= '0;
         s.lstate <= PCG_LS_OFF;
         s.ctrl <= PCG_CTRL_RST;
         s.refdv <= PCG_REF_RST;
         s.mult <= PCG_MUL_RST;
         s.slwdv <= PCG_SLW_RST;
      end
      else if (clk_en)
      begin
         s <= next_s;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign prdata = s.rdata;
   assign pready = psel & penable & s.ready;
   assign pslverr = psel & penable & s.ready & ~pcg_mapped(paddr);
   assign clocks = s.clk;
   assign bus_strobe_clock = s.clk.system_base_clock;
   assign calibration_out_clock = s.slw_lvl;
   assign final_reference_clock = s.ref_tick;
   assign vco_feedback_clock = s.fb_tick;
   assign loop_run = (s.lstate == PCG_LS_RUN);
   assign filter_track = acq_eff & (s.lstate == PCG_LS_RUN);
   assign monitor_enable = s.ctrl.monitor_enable_bit;
   assign limp_disable = s.ctrl.limp_disable_bit;
   assign settle_irq = s.irq;

   // wait mode deliberately has no effect on the loop
   logic unused_wait;
   assign unused_wait = wait_mode;

endmodule

`default_nettype wire

/* File: dv/pcg_sva.sv */
// checker: port-level properties of the clock generation control block
`timescale 1ns/1ps
`default_nettype none
module pcg_sva
   import pcg_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic pready,
   input wire logic external_clock_in,
   input wire logic debug_clock_in,
   input wire logic can_sel_system,
   input wire logic debug_sel_strobe,
   input wire logic stop_mode,
   input wire logic wait_mode,
   input wire pcg_clocks_t clocks,
   input wire logic bus_strobe_clock,
   input wire logic final_reference_clock,
   input wire logic vco_feedback_clock,
   input wire logic loop_run,
   input wire logic filter_track,
   input wire logic monitor_enable,
   input wire logic limp_disable,
   input wire logic settle_irq
);
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   // a completed write may legally change power or pending state
   logic wr_done;
   assign wr_done = psel && penable && pready && pwrite;
   sequence s_stop_left;
      $fell(stop_mode);
   endsequence
   sequence s_idle3;
      !loop_run [*3];
   endsequence
   a_reset_ctrl: assert property ($rose(rst_n) |-> monitor_enable && !limp_disable)
      else $error("control bits wrong after reset");
   a_track_run: assert property (filter_track |-> loop_run)
      else $error("tracking while loop not running");
   a_stop_halts: assert property (loop_run && stop_mode && clk_en |=> !loop_run)
      else $error("loop kept running in stop");
   // restart must keep the loop off for 8 cycles after stop ends, never jump straight back
   a_restart_wait: assert property (s_stop_left |-> !loop_run [*8])
      else $error("loop resumed without stabilisation");
   a_wait_keeps: assert property (loop_run && wait_mode && !stop_mode && clk_en && !wr_done
      |=> loop_run)
      else $error("loop stopped in wait");
   a_fb_idle: assert property (s_idle3 |-> !vco_feedback_clock)
      else $error("feedback pulse while loop idle");
   a_ref_pulse: assert property (final_reference_clock && clk_en |=> !final_reference_clock)
      else $error("reference pulse longer than one cycle");
   a_irq_sticky: assert property (settle_irq && clk_en && !wr_done |=> settle_irq)
      else $error("settle request dropped without a write");
   a_mon_direct: assert property (rst_n && clk_en
      |=> clocks.monitor_clock == $past(external_clock_in))
      else $error("monitor clock not from external clock");
   a_can_select: assert property (rst_n && clk_en
      |=> clocks.can_clock == ($past(can_sel_system) ?
      $past(clocks.system_base_clock) : $past(external_clock_in)))
      else $error("can clock source wrong");
   a_dbg_select: assert property (rst_n && clk_en
      |=> clocks.debug_module_clock == ($past(debug_sel_strobe)
      ? $past(bus_strobe_clock) : $past(debug_clock_in)))
      else $error("debug clock source wrong");
endmodule
bind pcg_clock_ctrl pcg_sva pcg_sva_inst (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
   .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
   .external_clock_in(external_clock_in), .debug_clock_in(debug_clock_in),
   .can_sel_system(can_sel_system), .debug_sel_strobe(debug_sel_strobe),
   .stop_mode(stop_mode), .wait_mode(wait_mode), .clocks(clocks),
   .bus_strobe_clock(bus_strobe_clock), .final_reference_clock(final_reference_clock),
   .vco_feedback_clock(vco_feedback_clock), .loop_run(loop_run), .filter_track(filter_track),
   .monitor_enable(monitor_enable), .limp_disable(limp_disable), .settle_irq(settle_irq));
`default_nettype wire

/* File: dv/pcg_clk_src.sv */
// partner model: crystal source and loop oscillator seen by the block
`timescale 1ns/1ps
`default_nettype none
module pcg_clk_src (
   input wire logic clk_sys,
   input wire logic loop_run,
   input wire logic [7:0] vco_half,
   output logic external_clock_in,
   output logic vco_output_clock
);
   // ------------------------------------------------------------
   // oscillators
   // ------------------------------------------------------------
   localparam int XTAL_HALF = 8;
   logic [7:0] xcnt = 8'h00;
   logic [7:0] vcnt = 8'h00;
   initial external_clock_in = 1'b0;
   initial vco_output_clock = 1'b0;
   // crystal runs free; the oscillator stands at 0 while the loop is stopped
   always @(posedge clk_sys)
   begin
      xcnt <= (xcnt == XTAL_HALF - 1) ? 8'h00 : xcnt + 8'h01;
      if (xcnt == XTAL_HALF - 1)
         external_clock_in <= !external_clock_in;
      if (!loop_run)
      begin
         vcnt <= 8'h00;
         vco_output_clock <= 1'b0;
      end
      else if (vcnt >= vco_half - 8'h01) // half period set by the bench
      begin
         vcnt <= 8'h00;
         vco_output_clock <= !vco_output_clock;
      end
      else
         vcnt <= vcnt + 8'h01;
   end
endmodule
`default_nettype wire

/* File: dv/tb.sv */
// testbench: register access, lock detection, stop and reset of the clock control block
`timescale 1ns/1ps
`default_nettype none
module tb
   import pcg_pkg::*;
;
   // ------------------------------------------------------------
   // stimulus, scoreboard and checks
   // ------------------------------------------------------------
   typedef struct packed {logic err; logic [31:0] mask; logic [31:0] exp;} pcg_note_t;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic clk_en = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata, rdata, v;
   logic pready, pslverr, external_clock_in, vco_output_clock;
   logic debug_clock_in = 1'b0;
   logic can_sel_system = 1'b0;
   logic debug_sel_strobe = 1'b0;
   logic stop_mode = 1'b0;
   logic wait_mode = 1'b0;
   logic [7:0] vco_half = 8'h04;
   pcg_clocks_t clocks;
   logic bus_strobe_clock, calibration_out_clock, final_reference_clock, vco_feedback_clock;
   logic loop_run, filter_track, monitor_enable, limp_disable, settle_irq;
   pcg_note_t notes[$];
   pcg_note_t note;
   integer seed = 49062;
   int err_total = 0;
   int checks_done = 0;

   pcg_clock_ctrl #(.STAB_CYCLES(20), .WINDOW(8)) pcg_clock_ctrl_inst (.clk_sys(clk_sys),
      .rst_n(rst_n), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .external_clock_in(external_clock_in), .vco_output_clock(vco_output_clock),
      .debug_clock_in(debug_clock_in), .can_sel_system(can_sel_system),
      .debug_sel_strobe(debug_sel_strobe), .stop_mode(stop_mode), .wait_mode(wait_mode),
      .clocks(clocks), .bus_strobe_clock(bus_strobe_clock),
      .calibration_out_clock(calibration_out_clock), .final_reference_clock(final_reference_clock),
      .vco_feedback_clock(vco_feedback_clock), .loop_run(loop_run), .filter_track(filter_track),
      .monitor_enable(monitor_enable), .limp_disable(limp_disable), .settle_irq(settle_irq));
   pcg_clk_src pcg_clk_src_inst (.clk_sys(clk_sys), .loop_run(loop_run), .vco_half(vco_half),
      .external_clock_in(external_clock_in), .vco_output_clock(vco_output_clock));

   initial
   begin
      forever #10 clk_sys = ~clk_sys;
   end
   // selects and debug clock toggle at random so both sources get exercised
   always @(posedge clk_sys)
   begin
      debug_clock_in <= 1'($random(seed));
      can_sel_system <= 1'($random(seed));
      debug_sel_strobe <= 1'($random(seed));
   end

   task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one apb transfer; the note is queued before the request goes out
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [31:0] m, input logic [31:0] e, input logic er);
      int n;
      n = 0;
      notes.push_back('{er, m, e});
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1)
         err_total++;
      rdata = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 32'h0, 32'h0, 1'b0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      bus(1'b0, a, 32'h0, m, e, 1'b0);
   endtask
   // status poll bounded at 300 reads; lock takes a few windows
   task automatic poll(input int b, input logic val);
      int k;
      k = 0;
      do
      begin
         rd(PCG_OFS_STAT, 32'h0, 32'h0);
         k++;
      end
      while (rdata[b] !== val && k < 300);
      cmp(33'(rdata[b]), 33'(val));
   endtask
   task automatic test_done();
      $display("checks=%0d errors=%0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // compares every completed transfer against the oldest note
   always @(posedge clk_sys)
   begin
      if (psel && penable && pready === 1'b1 && notes.size() > 0)
      begin
         note = notes.pop_front();
         cmp({pslverr, prdata & note.mask}, {note.err, note.exp & note.mask});
      end
   end
   initial
   begin
      #1200000;
      err_total++;
      test_done();
   end

   initial
   begin
      repeat (10) @(posedge clk_sys);
      rst_n <= 1'b1;
      rd(PCG_OFS_CTRL, 32'h48, 32'hFF);
      cmp(33'({monitor_enable, limp_disable}), 33'h2);
      bus(1'b0, 8'h0C, 32'h0, 32'hFFFFFFFF, 32'h0, 1'b1);
      bus(1'b1, 8'h0C, 32'hFFFFFFFF, 32'h0, 32'h0, 1'b1);
      for (int i = 0; i < 4; i++)
      begin
         v = (i == 0) ? 32'hFFFFFFFF : $random(seed);
         wr(PCG_OFS_DIV, v);
         rd(PCG_OFS_DIV, v & 32'h003F3F07, 32'hFFFFFFFF);
      end
      // divide by 2, multiply by 4: feedback matches reference when the oscillator is right
      wr(PCG_OFS_DIV, 32'h00000301);
      wr(PCG_OFS_CTRL, 32'h4D);
      poll(0, 1'b1);
      rd(PCG_OFS_STAT, 32'hF, 32'hF);
      cmp(33'(settle_irq), 33'h1);
      wr(PCG_OFS_CTRL, 32'h5D);
      rd(PCG_OFS_CTRL, 32'h5F, 32'hFF);
      wr(PCG_OFS_STAT, 32'h4);
      rd(PCG_OFS_STAT, 32'hB, 32'hF);
      cmp(33'(settle_irq), 33'h0);
      vco_half <= 8'h10;
      poll(0, 1'b0);
      poll(1, 1'b0);
      rd(PCG_OFS_STAT, 32'hC, 32'hF);
      rd(PCG_OFS_CTRL, 32'h5D, 32'hFF);
      wr(PCG_OFS_CTRL, 32'h4D);
      wr(PCG_OFS_STAT, 32'h4);
      wr(PCG_OFS_CTRL, 32'h44);
      wr(PCG_OFS_CTRL, 32'h4C);
      poll(3, 1'b1);
      wr(PCG_OFS_CTRL, 32'h4E);
      rd(PCG_OFS_CTRL, 32'h4E, 32'hFF);
      cmp(33'(filter_track), 33'h1);
      vco_half <= 8'h04;
      poll(0, 1'b1);
      rd(PCG_OFS_STAT, 32'h5, 32'h5);
      wr(PCG_OFS_CTRL, 32'h4C);
      repeat (2) @(posedge clk_sys);
      cmp(33'(filter_track), 33'h0);
      wr(PCG_OFS_CTRL, 32'h49);
      stop_mode <= 1'b1;
      repeat (10) @(posedge clk_sys);
      cmp(33'(loop_run), 33'h0);
      stop_mode <= 1'b0;
      poll(3, 1'b1);
      poll(0, 1'b1);
      wait_mode <= 1'b1;
      repeat (40) @(posedge clk_sys);
      cmp(33'(loop_run), 33'h1);
      wait_mode <= 1'b0;
      clk_en <= 1'b0;
      repeat (6) @(posedge clk_sys);
      clk_en <= 1'b1;
      wr(PCG_OFS_CTRL, 32'hA1);
      rd(PCG_OFS_CTRL, 32'hA1, 32'hFF);
      cmp(33'({monitor_enable, limp_disable}), 33'h1);
      cmp(33'(loop_run), 33'h0);
      rd(PCG_OFS_STAT, 32'h0, 32'hB);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      rd(PCG_OFS_CTRL, 32'h48, 32'hFF);
      cmp(33'({monitor_enable, limp_disable}), 33'h2);
      test_done();
   end
endmodule
`default_nettype wire
